// File: verilog/snph_link_mgr.sv
// Purpose: pairing handshake link manager for master and client nodes
// Assumes: all inputs except arst_n synchronous to clk; frame coding and crc done outside
// Notes: role_master picks the node role; registers reached over the serial register port
`timescale 1ns/1ps
module snph_link_mgr #(
    parameter int LISTEN_CYCLES = snph_pkg::SNPH_LISTEN_CYCLES, // one second listening
    parameter int ACK_WIN_CYCLES = snph_pkg::SNPH_ACK_WIN_CYCLES // acknowledge window
) (
    input wire logic clk,                             // 40 MHz system clock
    input wire logic arst_n,                          // async reset, active low
    input wire logic role_master,                     // 1 = master node, 0 = client
    input wire snph_pkg::snph_reg_req_t serial_register_port, // decoded register access
    output logic [7:0] reg_rdata,                     // read data
    output logic reg_rvalid,                          // read data valid pulse
    input wire logic wake_call_done,                  // master wake-up call finished
    input wire logic wake_event,                      // client wake-up cycle event
    input wire logic tx_cmd,                          // host transmit command pulse
    input wire logic tx_done,                         // frame coder finished sending
    input wire logic ack_detect,                      // acknowledge pattern seen
    input wire snph_pkg::snph_rx_t rx,                // receiver frame events
    input wire logic [23:0] own_ident,                // this client's identifier
    input wire logic [2:0] own_cyc,                   // this client's cycle time
    input wire logic [4:0] own_rnd,                   // this client's random pointer
    output snph_pkg::snph_tx_t tx,                    // transmit request
    output logic ack_send,                            // master sends acknowledge pulse
    output logic rx_on,                               // receiver enable level
    output logic tx_pending,                          // transmit command still pending
    output logic [7:0] timer_enable,                  // timer enable control bits
    output snph_pkg::snph_timing_t [7:0] client_timing, // per-client timing state
    output snph_pkg::snph_irq_t irq                   // interrupt event pulses
);
    import snph_pkg::*;

    snph_core_t q; // registered state
    snph_core_t d; // next state
    logic [SNPH_CLIENTS-1:0] match; // per-entry identifier compare
    logic hit_any; // some entry matched
    logic [2:0] hit_idx; // lowest matching entry
    logic [4:0] tbl_idx; // table byte selected by address

    // identifier compare against each table entry, low byte at lowest offset
    for (genvar k = 0; k < SNPH_CLIENTS; k++) begin : g_match
        assign match[k] = ({q.tbl[SNPH_ID_BYTES*k+2], q.tbl[SNPH_ID_BYTES*k+1],
                            q.tbl[SNPH_ID_BYTES*k]} == rx.id);
    end

    // priority pick: lowest slot wins if the host wrote a duplicate
    always_comb begin
        hit_idx = 3'h0;
        for (int i = SNPH_CLIENTS - 1; i >= 0; i--) begin
            if (match[i]) begin
                hit_idx = 3'(i);
            end
        end
        hit_any = |match;
        tbl_idx = 5'(serial_register_port.addr - SNPH_ADDR_TBL_FIRST);
    end

    // next-state logic for the whole block
    // one copy of the state is edited here and registered below
    always_comb begin
        d = q;
        // event outputs are one-cycle pulses
        d.tx.start = 1'b0;
        d.ack_send = 1'b0;
        d.irq = '0;
        d.rvalid = 1'b0;

        // register writes; read-only and unmapped offsets ignore writes
        // the table is the host's only way to admit a client
        if (serial_register_port.wr) begin
            if (serial_register_port.addr == SNPH_ADDR_TIMER_CTRL) begin
                d.timer_ctrl = serial_register_port.wdata;
            end else if (serial_register_port.addr >= SNPH_ADDR_TBL_FIRST &&
                         serial_register_port.addr <= SNPH_ADDR_TBL_LAST) begin
                d.tbl[tbl_idx] = serial_register_port.wdata;
            end
        end

        // register reads answer one cycle later; unmapped reads return zero
        // a read and a write of one byte together return the old value
        if (serial_register_port.rd) begin
            d.rvalid = 1'b1;
            if (serial_register_port.addr == SNPH_ADDR_TIMER_CTRL) begin
                d.rdata = q.timer_ctrl;
            end else if (serial_register_port.addr >= SNPH_ADDR_TBL_FIRST &&
                         serial_register_port.addr <= SNPH_ADDR_TBL_LAST) begin
                d.rdata = q.tbl[tbl_idx];
            end else if (serial_register_port.addr == SNPH_ADDR_UNK_ID0) begin
                d.rdata = q.unknown_client_ident[7:0];
            end else if (serial_register_port.addr == SNPH_ADDR_UNK_ID1) begin
                d.rdata = q.unknown_client_ident[15:8];
            end else if (serial_register_port.addr == SNPH_ADDR_UNK_ID2) begin
                d.rdata = q.unknown_client_ident[23:16];
            end else begin
                d.rdata = SNPH_READ_ZERO;
            end
        end

        case (q.st)
            ST_IDLE: begin
                // receiver events here are outside the window and dropped
                if (role_master && wake_call_done) begin
                    d.st = ST_LISTEN;
                    d.cnt = SNPH_CNT_W'(LISTEN_CYCLES - 1);
                    d.rx_on = 1'b1;
                    d.id_seen = 1'b0;
                end else if (!role_master && tx_cmd) begin
                    // host timing of the command is its own business
                    d.st = ST_TX;
                    d.tx_pending = 1'b1;
                    d.tx.start = 1'b1;
                    d.tx.len = SNPH_PAYLOAD_LEN;
                    d.tx.payload = {own_ident, own_cyc, own_rnd, SNPH_PAD_BYTE};
                end
            end
            ST_LISTEN: begin
                // identifier field arrives before the crc verdict
                if (rx.id_valid) begin
                    d.cur_id = rx.id;
                    d.id_seen = 1'b1;
                    d.hit = hit_any;
                    d.hit_idx = hit_idx;
                    d.hit_was_active = q.timing[hit_idx].active;
                    // load timing at once, but only for a client not yet running
                    if (hit_any && !q.timing[hit_idx].active) begin
                        d.timing[hit_idx].cyc = rx.cyc;
                        d.timing[hit_idx].rnd = rx.rnd;
                    end
                end
                // verdict at frame end; a bad crc starts nothing and sends nothing
                if (rx.frame_end && q.id_seen) begin
                    d.id_seen = 1'b0;
                    if (rx.crc_ok && q.hit && !q.hit_was_active) begin
                        d.timing[q.hit_idx].active = 1'b1;
                        d.ack_send = 1'b1;
                        d.irq.data_rx = 1'b1;
                    end else if (rx.crc_ok && !q.hit) begin
                        // absent from the table: flag it, never acknowledge it
                        d.irq.unknown_client_irq = 1'b1;
                        d.unknown_client_ident = q.cur_id;
                    end
                    // a hit on an active client falls through untouched
                end
                // listening window ends by itself
                // the zero count is a window cycle too, so it lasts the full count
                if (q.cnt == '0) begin
                    d.st = ST_IDLE;
                    d.rx_on = 1'b0;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            ST_TX: begin
                // wait for the coder, then listen for the acknowledge
                if (tx_done) begin
                    d.st = ST_ACKWIN;
                    d.cnt = SNPH_CNT_W'(ACK_WIN_CYCLES - 1);
                    d.rx_on = 1'b1;
                end
            end
            ST_ACKWIN: begin
                // an acknowledge in the last window cycle still wins
                if (ack_detect) begin
                    d.irq.ack_rx = 1'b1;
                    d.tx_pending = 1'b0;
                    d.rx_on = 1'b0;
                    d.st = ST_STANDBY;
                end else if (q.cnt == '0) begin
                    // command stays pending so the host can retry later
                    d.rx_on = 1'b0;
                    d.irq.rx_end = 1'b1;
                    d.st = ST_IDLE;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            ST_STANDBY: begin
                // timers are off, so only a wake-up event moves on
                if (wake_event) begin
                    d.st = ST_IDLE;
                end
            end
            default: begin
                d.st = ST_IDLE;
                d.rx_on = 1'b0;
            end
        endcase
    end

    // single state register
    // reset clears the table, so the host must reload it afterwards
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= SNPH_CORE_RST;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    // nothing combinational reaches a pin, so the far side sees clean edges
    assign reg_rdata = q.rdata;
    assign reg_rvalid = q.rvalid;
    assign tx = q.tx;
    assign ack_send = q.ack_send;
    assign rx_on = q.rx_on;
    assign tx_pending = q.tx_pending;
    assign timer_enable = q.timer_ctrl;
    assign client_timing = q.timing;
    assign irq = q.irq;

    // assertion checks
    // all checks live in the clk domain and sleep during reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // a wake-up call seen in idle opens the window next edge
    listen_start_a: assert property (
        q.st == ST_IDLE && role_master && wake_call_done
        |=> q.st == ST_LISTEN && q.rx_on && q.cnt == SNPH_CNT_W'(LISTEN_CYCLES - 1))
        else $error("listening window did not open after wake-up call");

    // the receiver stays on until the counter has run down
    listen_hold_a: assert property (
        q.st == ST_LISTEN && q.cnt != '0 |=> q.st == ST_LISTEN && q.rx_on)
        else $error("listening window closed early");

    // timing is taken at identifier arrival, before the crc verdict
    timing_load_a: assert property (
        q.st == ST_LISTEN && rx.id_valid && hit_any && !q.timing[hit_idx].active
        |=> q.timing[$past(hit_idx)].cyc == $past(rx.cyc)
            && q.timing[$past(hit_idx)].rnd == $past(rx.rnd))
        else $error("timing not loaded on identifier arrival");

    // a good frame from a new client is acknowledged and reported
    accept_ack_a: assert property (
        q.st == ST_LISTEN && rx.frame_end && q.id_seen && rx.crc_ok && q.hit
        && !q.hit_was_active |=> ack_send && irq.data_rx && q.timing[$past(q.hit_idx)].active)
        else $error("accepted client not acknowledged");

    // a bad crc leaves every slot as it was
    crc_fail_a: assert property (
        q.st == ST_LISTEN && rx.frame_end && !rx.crc_ok
        |=> !ack_send && !irq.data_rx && client_timing == $past(client_timing))
        else $error("crc failure changed state or sent acknowledge");

    // a stranger is reported and its identifier kept for the host
    unknown_id_a: assert property (
        q.st == ST_LISTEN && rx.frame_end && q.id_seen && rx.crc_ok && !q.hit
        |=> irq.unknown_client_irq && !ack_send && q.unknown_client_ident == $past(q.cur_id))
        else $error("unknown identifier not flagged or stored");

    // a running client is neither reloaded nor acknowledged
    active_kept_a: assert property (
        q.st == ST_LISTEN && (rx.frame_end || rx.id_valid) && q.hit && q.hit_was_active
        && !rx.id_valid |=> client_timing == $past(client_timing) && !ack_send)
        else $error("active client state was changed");

    // no pairing event outside the listening window
    outside_window_a: assert property (
        q.st != ST_LISTEN |=> !ack_send && !irq.data_rx && !irq.unknown_client_irq)
        else $error("pairing event outside listening window");

    // client side: a finished send opens the acknowledge window
    ack_window_a: assert property (
        q.st == ST_TX && tx_done |=> q.st == ST_ACKWIN && rx_on)
        else $error("acknowledge window not opened after send");

    // an acknowledge ends the command and parks the client
    ack_seen_a: assert property (
        q.st == ST_ACKWIN && ack_detect
        |=> irq.ack_rx && !tx_pending && q.st == ST_STANDBY ##1 !rx_on)
        else $error("acknowledge not handled");

    // only the wake-up event leaves standby
    standby_stay_a: assert property (
        q.st == ST_STANDBY && !wake_event |=> q.st == ST_STANDBY)
        else $error("client left standby without wake-up event");

    // a timeout keeps the command pending so the host can retry
    ack_timeout_a: assert property (
        q.st == ST_ACKWIN && q.cnt == '0 && !ack_detect
        |=> irq.rx_end && tx_pending && !rx_on && q.st == ST_IDLE)
        else $error("acknowledge timeout mishandled");

    // every started frame is the five-byte announcement
    payload_len_a: assert property (
        $rose(tx.start) |-> tx.len == SNPH_PAYLOAD_LEN && tx_pending && q.st == ST_TX)
        else $error("pairing frame length wrong");

    // window end, refusals, identifier read-back and pulse shapes
    listen_end_a: assert property (
        q.st == ST_LISTEN && q.cnt == '0 |=> q.st == ST_IDLE && !rx_on)
        else $error("listening window did not close");

    standby_refuse_a: assert property (
        q.st == ST_STANDBY && tx_cmd |=> !tx.start && !tx_pending)
        else $error("transmit command taken in standby");

    ident_read_a: assert property (
        serial_register_port.rd && serial_register_port.addr == SNPH_ADDR_UNK_ID2
        |=> reg_rvalid && reg_rdata == $past(q.unknown_client_ident[23:16]))
        else $error("unknown identifier read back wrong");

    ack_only_a: assert property (
        ack_send |-> irq.data_rx && !irq.unknown_client_irq)
        else $error("acknowledge without an accepted client");

    start_pulse_a: assert property (
        tx.start |=> !tx.start)
        else $error("transmit start longer than one cycle");

    // main scenarios the bench should reach
    accept_c: cover property (
        q.st == ST_LISTEN && rx.frame_end && rx.crc_ok && q.hit ##1 ack_send);
    unknown_c: cover property (irq.unknown_client_irq);
    client_ack_c: cover property (q.st == ST_ACKWIN ##[1:20] irq.ack_rx);
    client_timeout_c: cover property (irq.rx_end ##[1:50] tx.start);
    listen_close_c: cover property (q.st == ST_LISTEN ##1 q.st == ST_IDLE);
endmodule

// File: pkg/snph_pkg.sv
// Purpose: shared constants and types for the star network pairing link manager
// Assumes: 40 MHz system clock, register offsets as seen on the serial register port
// Notes: every offset, reset value and default timing count lives here; port widths are set in the module
package snph_pkg;
    // clock and timing figures, each in its own unit
    localparam int SNPH_CLK_MHZ = 40;              // system clock rate
    localparam int SNPH_US_PER_MS = 1000;          // unit conversion
    localparam int SNPH_LISTEN_TIME_MS = 1000;     // master listening window after wake-up
    localparam int SNPH_LISTEN_CYCLES = SNPH_LISTEN_TIME_MS * SNPH_US_PER_MS * SNPH_CLK_MHZ;
    localparam int SNPH_ACK_WIN_US = 100;          // client acknowledge window, plain default
    localparam int SNPH_ACK_WIN_CYCLES = SNPH_ACK_WIN_US * SNPH_CLK_MHZ;
    localparam int SNPH_CNT_W = 26;                // holds the listening count
    // table geometry
    localparam int SNPH_CLIENTS = 8;               // paired client slots
    localparam int SNPH_ID_BYTES = 3;              // identifier is three bytes
    localparam int SNPH_TBL_BYTES = 24;            // identifier table size
    // register offsets
    localparam logic [5:0] SNPH_ADDR_TIMER_CTRL = 6'h01;
    localparam logic [5:0] SNPH_ADDR_TBL_FIRST = 6'h08;
    localparam logic [5:0] SNPH_ADDR_TBL_LAST = 6'h1f;
    localparam logic [5:0] SNPH_ADDR_UNK_ID0 = 6'h34;
    localparam logic [5:0] SNPH_ADDR_UNK_ID1 = 6'h35;
    localparam logic [5:0] SNPH_ADDR_UNK_ID2 = 6'h36;
    // reset values and frame constants
    localparam logic [7:0] SNPH_TIMER_CTRL_RST = 8'h00;
    localparam logic [7:0] SNPH_READ_ZERO = 8'h00;
    localparam logic [2:0] SNPH_PAYLOAD_LEN = 3'h5; // first pairing frame payload bytes
    localparam logic [7:0] SNPH_PAD_BYTE = 8'h00;   // fifth payload byte

    // link manager states
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_LISTEN  = 3'b001,
        ST_TX      = 3'b010,
        ST_ACKWIN  = 3'b011,
        ST_STANDBY = 3'b100
    } snph_state_t;

    // decoded serial register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } snph_reg_req_t;

    // receiver events from the frame decoder
    typedef struct packed {
        logic        id_valid;   // identifier field complete
        logic [23:0] id;
        logic [2:0]  cyc;        // received cycle time
        logic [4:0]  rnd;        // received random pointer
        logic        frame_end;  // frame complete, crc_ok valid
        logic        crc_ok;
    } snph_rx_t;

    // transmit request to the frame coder
    typedef struct packed {
        logic        start;
        logic [2:0]  len;
        logic [39:0] payload;
    } snph_tx_t;

    // interrupt event pulses
    typedef struct packed {
        logic data_rx;
        logic unknown_client_irq;
        logic ack_rx;
        logic rx_end;
    } snph_irq_t;

    // per-client timing state
    typedef struct packed {
        logic       active;
        logic [2:0] cyc;
        logic [4:0] rnd;
    } snph_timing_t;

    // whole state of the link manager
    typedef struct packed {
        snph_state_t                        st;
        logic [SNPH_CNT_W-1:0]              cnt;
        logic [7:0]                         timer_ctrl;
        logic [SNPH_TBL_BYTES-1:0][7:0]     tbl;
        snph_timing_t [SNPH_CLIENTS-1:0]    timing;
        logic [23:0]                        cur_id;
        logic                               id_seen;
        logic                               hit;
        logic [2:0]                         hit_idx;
        logic                               hit_was_active;
        logic [23:0]                        unknown_client_ident;
        logic                               tx_pending;
        logic                               rx_on;
        logic                               ack_send;
        snph_tx_t                           tx;
        snph_irq_t                          irq;
        logic [7:0]                         rdata;
        logic                               rvalid;
    } snph_core_t;

    localparam snph_core_t SNPH_CORE_RST = '0;
endpackage

// File: tb/snph_peer_model.sv
// Purpose: far-side radio peer that feeds decoded frames and link events
// Assumes: the bench calls frame() and sets ack_en for the client runs
// Notes: released frame fields show the inverse of the last value until the crc verdict, then the last value again
`timescale 1ns/1ps
module snph_peer_model (
    input wire logic clk, // system clock
    input wire snph_pkg::snph_tx_t tx, // transmit request of the block
    output snph_pkg::snph_rx_t rx, // decoded frame events
    output logic tx_done, // frame sent pulse
    output logic ack_detect // acknowledge pattern seen pulse
);
    import snph_pkg::*;
    bit ack_en = 0; // the far master accepts this client
    initial begin
        rx = '0;
        tx_done = 1'b0;
        ack_detect = 1'b0;
    end
    // one frame: identifier first, crc verdict four cycles later
    task automatic frame(input logic [23:0] id, input logic [7:0] ct, input bit ok);
        @(posedge clk) rx <= {1'b1, id, ct, 2'b00};
        @(posedge clk) rx <= {1'b0, ~id, ~ct, 2'b00};
        repeat (3) @(posedge clk);
        rx <= {1'b0, ~id, ~ct, 1'b1, ok};
        // fields move again so a stale value cannot pass for a fresh one
        @(posedge clk) rx <= {1'b0, id, ct, 2'b00};
    endtask
    // coder finishes each started frame; a master answer only when told to
    initial forever begin
        @(posedge clk);
        #1;
        if (tx.start === 1'b1) begin
            repeat ($urandom_range(9, 2)) @(posedge clk);
            tx_done <= 1'b1;
            @(posedge clk) tx_done <= 1'b0;
            if (ack_en) begin
                // answer well inside the acknowledge window
                repeat ($urandom_range(20, 3)) @(posedge clk);
                ack_detect <= 1'b1;
                @(posedge clk) ack_detect <= 1'b0;
            end
        end
    end
endmodule

// File: tb/testbench.sv
// Purpose: self-checking bench for the pairing link manager in both roles
// Assumes: short listening and acknowledge windows set through parameters
// Notes: a model of the register map, timing slots and event counts checks each result
`timescale 1ns/1ps
module testbench;
    import snph_pkg::*;
    localparam int LW = 200; // shortened listening window
    localparam int AW = 40; // shortened acknowledge window
    logic clk, arst_n, role_master, wake_call_done, wake_event, tx_cmd;
    snph_reg_req_t req; // register access
    logic [23:0] own_ident;
    logic [2:0] own_cyc;
    logic [4:0] own_rnd;
    logic [7:0] reg_rdata, timer_enable;
    logic reg_rvalid, ack_send, rx_on, tx_pending, tx_done, ack_detect;
    snph_rx_t rx;
    snph_tx_t tx;
    snph_timing_t [7:0] client_timing;
    snph_irq_t irq;
    logic [5:0] pv; // watched pulses
    int n_errors = 0, checked = 0, cyc_n = 0, t;
    int cnt[6], ex[6]; // seen and expected pulse counts
    logic [7:0] mreg[64]; // register map model
    logic [8:0] mtim[8]; // timing slot model
    logic [23:0] id_a, id_b, id_u;
    logic [7:0] ct;
    snph_link_mgr #(.LISTEN_CYCLES(LW), .ACK_WIN_CYCLES(AW)) i_snph_link_mgr (
        .clk(clk), .arst_n(arst_n), .role_master(role_master),
        .serial_register_port(req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .wake_call_done(wake_call_done), .wake_event(wake_event), .tx_cmd(tx_cmd),
        .tx_done(tx_done), .ack_detect(ack_detect), .rx(rx), .own_ident(own_ident),
        .own_cyc(own_cyc), .own_rnd(own_rnd), .tx(tx), .ack_send(ack_send),
        .rx_on(rx_on), .tx_pending(tx_pending), .timer_enable(timer_enable),
        .client_timing(client_timing), .irq(irq));
    snph_peer_model i_peer (.clk(clk), .tx(tx), .rx(rx), .tx_done(tx_done),
        .ack_detect(ack_detect));
    assign pv = {tx.start, irq.rx_end, irq.ack_rx, irq.unknown_client_irq, irq.data_rx, ack_send};
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // count each of the six watched one-cycle events the block raises
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        for (int i = 0; i < 6; i++) if (arst_n === 1'b1 && pv[i] === 1'b1) cnt[i]++;
    end
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic pulses();
        for (int i = 0; i < 6; i++) chk("event count", ex[i], cnt[i]);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk) req <= {1'b1, 1'b0, a, d};
        @(posedge clk) req <= '0;
        #1;
        // only the timer control and the table take writes
        if (a == 6'h01 || (a >= 6'h08 && a <= 6'h1f)) mreg[a] = d;
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge clk) req <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clk) req <= '0;
        #1;
        chk("read valid", 1, reg_rvalid);
        chk("read data", mreg[a], reg_rdata);
    endtask
    // one-cycle pulse: 0 wake call done, 1 wake event, 2 transmit command
    task automatic kick(input int k);
        @(posedge clk) {wake_call_done, wake_event, tx_cmd} <= 3'b100 >> k;
        @(posedge clk) {wake_call_done, wake_event, tx_cmd} <= 3'b000;
        #1;
    endtask
    // one received frame; lowest matching slot wins, nothing outside the window
    task automatic send(input logic [23:0] id, input bit ok, input bit inw);
        int s;
        s = inw ? -1 : -2;
        ct = 8'($urandom);
        for (int k = 7; k >= 0; k--)
            if (inw && {mreg[3*k+10], mreg[3*k+9], mreg[3*k+8]} == id) s = k;
        if (s >= 0 && !mtim[s][8]) mtim[s][7:0] = ct;
        fork
            i_peer.frame(id, ct, ok);
            begin
                repeat (3) @(posedge clk);
                #1;
                if (s >= 0) chk("early timing", mtim[s], client_timing[s]);
            end
        join
        repeat (2) @(posedge clk);
        #1;
        if (s >= 0 && ok && !mtim[s][8]) begin
            mtim[s][8] = 1'b1;
            ex[0]++;
            ex[1]++;
        end
        if (s == -1 && ok) begin
            ex[2]++;
            {mreg[54], mreg[53], mreg[52]} = id;
        end
        pulses();
        for (int k = 0; k < 8; k++) chk("timing", mtim[k], client_timing[k]);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // a hang is cut short well past the longest expected run
    initial begin
        #(25 * 20000);
        n_errors++;
        $display("CHECK FAILED watchdog expected end seen hang");
        final_report();
    end
    initial begin
        void'($urandom(32'h0bbb));
        {arst_n, wake_call_done, wake_event, tx_cmd, own_ident, own_cyc, own_rnd} = '0;
        req = '0;
        role_master = 1'b1;
        foreach (mreg[i]) mreg[i] = 8'h00;
        foreach (mtim[i]) mtim[i] = 9'h000;
        foreach (cnt[i]) {cnt[i], ex[i]} = '0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        rd(6'h01);
        rd(6'h08);
        rd(6'h3f);
        id_a = $urandom | 24'h00_0001;
        id_b = id_a ^ 24'h80_0000;
        id_u = id_a ^ 24'h40_0000;
        wr(6'h01, 8'($urandom));
        rd(6'h01);
        wr(6'h01, 8'h00);
        chk("timer enable", mreg[1], timer_enable);
        for (int b = 0; b < 3; b++) wr(6'(8 + b), id_a[8*b +: 8]);
        for (int b = 0; b < 3; b++) wr(6'(11 + b), id_b[8*b +: 8]);
        rd(6'h0c);
        wr(6'h34, 8'h5a);
        rd(6'h34);
        send(id_a, 1'b1, 1'b0);
        kick(0);
        t = cyc_n;
        chk("listening", 1, rx_on);
        send(id_a, 1'b1, 1'b1);
        send(id_b, 1'b0, 1'b1);
        send(id_u, 1'b1, 1'b1);
        for (int b = 0; b < 3; b++) rd(6'(52 + b));
        send(id_u, 1'b1, 1'b1);
        send(id_a, 1'b1, 1'b1);
        while (rx_on === 1'b1 && cyc_n - t < 400) @(posedge clk) #1;
        chk("listen length", LW, cyc_n - t);
        send(id_u, 1'b1, 1'b0);
        for (int b = 0; b < 3; b++) wr(6'(14 + b), id_u[8*b +: 8]);
        kick(0);
        send(id_u, 1'b1, 1'b1);
        send(id_b, 1'b1, 1'b1);
        // client role from a fresh reset
        arst_n <= 1'b0;
        role_master <= 1'b0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        {own_ident, own_cyc, own_rnd} <= $urandom;
        repeat ($urandom_range(9, 1)) @(posedge clk);
        kick(2);
        ex[5]++;
        chk("frame length", 5, tx.len);
        chk("frame payload", {own_ident, own_cyc, own_rnd, 8'h00}, tx.payload);
        t = cyc_n;
        while (rx_on !== 1'b1 && cyc_n - t < 50) @(posedge clk) #1;
        t = cyc_n;
        while (rx_on === 1'b1 && cyc_n - t < 400) @(posedge clk) #1;
        chk("ack window", AW, cyc_n - t);
        @(posedge clk) #1;
        ex[4]++;
        pulses();
        chk("still pending", 1, tx_pending);
        i_peer.ack_en = 1;
        repeat ($urandom_range(9, 1)) @(posedge clk);
        kick(2);
        ex[5]++;
        t = cyc_n;
        while (tx_pending === 1'b1 && cyc_n - t < 100) @(posedge clk) #1;
        @(posedge clk) #1;
        ex[3]++;
        pulses();
        chk("receiver off", 0, rx_on);
        kick(2);
        repeat (2) @(posedge clk) #1;
        pulses();
        kick(1);
        kick(2);
        ex[5]++;
        @(posedge clk) #1;
        pulses();
        final_report();
    end
endmodule
